// File: hw/jbt_tap.sv
// boundary-scan test access port, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - instruction register is ten bits, shifted from test input to test output
// - sample/preload captures pins, loads pattern, normal operation untouched
// - extest drives outputs from scan register, captures input pins
// - bypass places a one-bit register in the scan path
// - usercode shifts out the 32-bit user code register
// - user code defaults to all ones when none configured
// - idcode shifts out the identification register
// - id is version, part number, maker identity, lsb one
// - highz selects bypass and floats every pin
// - clamp selects bypass, pins held from scan register
// - two user codes route scan path through first or second user chain
// - highz, clamp, extest keep pull-ups and bus-hold working
// - scan register length is a device-dependent constant
// - programming instruction set shares the port; not implemented here
module jbt_tap #(
    parameter int BSR_LEN = jbt_pkg::BSR_LEN_SMALL,
    parameter int N_PINS = 8,
    // identity fields: values arbitrary
    parameter logic [3:0] ID_VERSION = 4'h0,
    parameter logic [15:0] ID_PART = 16'h1234,
    parameter logic [10:0] ID_MFR = 11'h055,
    parameter logic [31:0] USERCODE = jbt_pkg::USERCODE_RESET
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE_N,
    input wire logic [N_PINS-1:0] PIN_IN,
    input wire logic [N_PINS-1:0] CORE_OUT,
    input wire logic [N_PINS-1:0] CORE_OE_N,
    output logic [N_PINS-1:0] PIN_OUT,
    output logic [N_PINS-1:0] PIN_OE_N,
    output logic PIN_KEEPERS_ON,
    output logic USER_A_SEL,
    output logic USER_B_SEL,
    output logic USER_CAPTURE,
    output logic USER_SHIFT,
    output logic USER_UPDATE,
    output logic USER_TDI,
    input wire logic USER_A_TDO,
    input wire logic USER_B_TDO
);
    // ****************************************
    // input synchronisers and tck edges
    // ****************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic tck_d;
    // reset to the pulled-up idle levels, so no false tck edge follows reset
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            tck_d <= 1'b1;
        end else begin
            sync1 <= {TCK, TMS, TDI};
            sync2 <= sync1;
            tck_d <= sync2[2];
        end
    end
    wire tms_s = sync2[1];
    wire tdi_s = sync2[0];
    wire tck_rise = sync2[2] & ~tck_d;
    wire tck_fall = ~sync2[2] & tck_d;

    // ****************************************
    // tap controller
    // ****************************************
    jbt_pkg::jbt_state_t state;
    jbt_pkg::jbt_state_t next_state;
    always_comb begin
        case (state)
            jbt_pkg::ST_TLR: next_state = tms_s ? jbt_pkg::ST_TLR : jbt_pkg::ST_RTI;
            jbt_pkg::ST_RTI: next_state = tms_s ? jbt_pkg::ST_SDS : jbt_pkg::ST_RTI;
            jbt_pkg::ST_SDS: next_state = tms_s ? jbt_pkg::ST_SIS : jbt_pkg::ST_CDR;
            jbt_pkg::ST_CDR: next_state = tms_s ? jbt_pkg::ST_E1D : jbt_pkg::ST_SDR;
            jbt_pkg::ST_SDR: next_state = tms_s ? jbt_pkg::ST_E1D : jbt_pkg::ST_SDR;
            jbt_pkg::ST_E1D: next_state = tms_s ? jbt_pkg::ST_UDR : jbt_pkg::ST_PDR;
            jbt_pkg::ST_PDR: next_state = tms_s ? jbt_pkg::ST_E2D : jbt_pkg::ST_PDR;
            jbt_pkg::ST_E2D: next_state = tms_s ? jbt_pkg::ST_UDR : jbt_pkg::ST_SDR;
            jbt_pkg::ST_UDR: next_state = tms_s ? jbt_pkg::ST_SDS : jbt_pkg::ST_RTI;
            jbt_pkg::ST_SIS: next_state = tms_s ? jbt_pkg::ST_TLR : jbt_pkg::ST_CIR;
            jbt_pkg::ST_CIR: next_state = tms_s ? jbt_pkg::ST_E1I : jbt_pkg::ST_SIR;
            jbt_pkg::ST_SIR: next_state = tms_s ? jbt_pkg::ST_E1I : jbt_pkg::ST_SIR;
            jbt_pkg::ST_E1I: next_state = tms_s ? jbt_pkg::ST_UIR : jbt_pkg::ST_PIR;
            jbt_pkg::ST_PIR: next_state = tms_s ? jbt_pkg::ST_E2I : jbt_pkg::ST_PIR;
            jbt_pkg::ST_E2I: next_state = tms_s ? jbt_pkg::ST_UIR : jbt_pkg::ST_SIR;
            jbt_pkg::ST_UIR: next_state = tms_s ? jbt_pkg::ST_SDS : jbt_pkg::ST_RTI;
            default: next_state = jbt_pkg::ST_TLR;
        endcase
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state <= jbt_pkg::ST_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ****************************************
    // instruction decode
    // ****************************************
    logic [9:0] ir_shift;
    logic [9:0] ir;
    wire sel_sample = (ir == jbt_pkg::IR_SAMPLE);
    wire sel_extest = (ir == jbt_pkg::IR_EXTEST);
    wire sel_usercode = (ir == jbt_pkg::IR_USERCODE);
    wire sel_idcode = (ir == jbt_pkg::IR_IDCODE);
    wire sel_highz = (ir == jbt_pkg::IR_HIGHZ);
    wire sel_clamp = (ir == jbt_pkg::IR_CLAMP);
    wire sel_user_a = (ir == jbt_pkg::IR_USER_A);
    wire sel_user_b = (ir == jbt_pkg::IR_USER_B);
    wire sel_bsr = sel_sample | sel_extest;
    wire sel_dr32 = sel_usercode | sel_idcode;
    // unsupported codes fall back to bypass rather than anything undefined
    wire sel_bypass = ~(sel_bsr | sel_dr32 | sel_user_a | sel_user_b);

    wire in_cdr = (state == jbt_pkg::ST_CDR);
    wire in_sdr = (state == jbt_pkg::ST_SDR);
    wire in_udr = (state == jbt_pkg::ST_UDR);
    wire in_sir = (state == jbt_pkg::ST_SIR);
    wire cap_dr = tck_rise & in_cdr;
    wire sh_dr = tck_rise & in_sdr;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ir_shift <= jbt_pkg::IR_CAPTURE;
        end else if (tck_rise && state == jbt_pkg::ST_CIR) begin
            ir_shift <= jbt_pkg::IR_CAPTURE;
        end else if (tck_rise && in_sir) begin
            ir_shift <= {tdi_s, ir_shift[9:1]};
        end
    end
    // reset to idcode, apply at update
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ir <= jbt_pkg::IR_IDCODE;
        end else if (state == jbt_pkg::ST_TLR) begin
            ir <= jbt_pkg::IR_IDCODE;
        end else if (tck_fall && state == jbt_pkg::ST_UIR) begin
            ir <= ir_shift;
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    logic bypass;
    logic [31:0] dr32;
    logic [BSR_LEN-1:0] bsr;
    logic [N_PINS-1:0] bsr_upd_out;
    logic [N_PINS-1:0] bsr_upd_oe_n;
    wire [31:0] id_value = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
    // bsr cells: inputs, then outputs, then enables; rest are spare
    wire [BSR_LEN-1:0] bsr_capture = {{(BSR_LEN - 3 * N_PINS){1'b0}}, CORE_OE_N, CORE_OUT,
                                      PIN_IN};

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bypass <= 1'b0;
        end else if (cap_dr) begin
            bypass <= 1'b0;
        end else if (sh_dr && sel_bypass) begin
            bypass <= tdi_s;
        end
    end
    // user code or id capture, shift
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dr32 <= 32'h0000_0000;
        end else if (cap_dr && sel_dr32) begin
            dr32 <= sel_usercode ? USERCODE : id_value;
        end else if (sh_dr && sel_dr32) begin
            dr32 <= {tdi_s, dr32[31:1]};
        end
    end
    // sample captures pins, fixed length chain
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bsr <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr <= bsr_capture;
        end else if (sh_dr && sel_bsr) begin
            bsr <= {tdi_s, bsr[BSR_LEN-1:1]};
        end
    end
    // update latches steer pins only under extest or clamp
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bsr_upd_out <= '0;
            bsr_upd_oe_n <= '1;
        end else if (tck_fall && in_udr && sel_bsr) begin
            bsr_upd_out <= bsr[2*N_PINS-1:N_PINS];
            bsr_upd_oe_n <= bsr[3*N_PINS-1:2*N_PINS];
        end
    end

    // ****************************************
    // pin control and outputs
    // ****************************************
    // extest and clamp drive from update latches
    wire pins_from_bsr = sel_extest | sel_clamp;
    assign PIN_OE_N = sel_highz ? {N_PINS{1'b1}} : (pins_from_bsr ? bsr_upd_oe_n : CORE_OE_N);
    assign PIN_OUT = pins_from_bsr ? bsr_upd_out : CORE_OUT;
    // keepers stay on in every mode
    assign PIN_KEEPERS_ON = 1'b1;

    assign USER_A_SEL = sel_user_a;
    assign USER_B_SEL = sel_user_b;
    assign USER_CAPTURE = in_cdr;
    assign USER_SHIFT = in_sdr;
    assign USER_UPDATE = in_udr;
    assign USER_TDI = tdi_s;

    wire tdo_dr = sel_bsr ? bsr[0] : sel_dr32 ? dr32[0] : sel_user_a ? USER_A_TDO :
                  sel_user_b ? USER_B_TDO : bypass;
    wire shifting = in_sdr | in_sir;
    // tdo changes on falling tck, as the host samples on rising
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            TDO <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else if (tck_fall) begin
            TDO <= in_sir ? ir_shift[0] : tdo_dr;
            TDO_OE_N <= ~shifting;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_TLR_IDCODE: assert property (@(posedge SYS_CLK) disable iff (RST)
        (state == jbt_pkg::ST_TLR) |=> sel_idcode)
        else $error("test-logic-reset did not select idcode");
    AST_IR_UPDATE: assert property (@(posedge SYS_CLK) disable iff (RST)
        (tck_fall && state == jbt_pkg::ST_UIR) |=> (ir == $past(ir_shift)))
        else $error("instruction not applied at update");
    AST_IR_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
        (state != jbt_pkg::ST_UIR && state != jbt_pkg::ST_TLR) |=> $stable(ir))
        else $error("instruction changed outside update");
    AST_TMS_RESET: assert property (@(posedge SYS_CLK) disable iff (RST)
        (tck_rise && tms_s && state == jbt_pkg::ST_SIS) |=> state == jbt_pkg::ST_TLR)
        else $error("tms high from select-ir did not reset");
    AST_HIGHZ: assert property (@(posedge SYS_CLK) disable iff (RST)
        sel_highz |-> (PIN_OE_N == {N_PINS{1'b1}}))
        else $error("pin driven under highz");
    AST_BYPASS_CAP: assert property (@(posedge SYS_CLK) disable iff (RST)
        cap_dr |=> !bypass)
        else $error("bypass did not capture zero");
    AST_ID_CAP: assert property (@(posedge SYS_CLK) disable iff (RST)
        (cap_dr && sel_idcode) |=> (dr32 == id_value && dr32[0]))
        else $error("idcode capture wrong");
    AST_USER_CAP: assert property (@(posedge SYS_CLK) disable iff (RST)
        (cap_dr && sel_usercode) |=> dr32 == USERCODE)
        else $error("usercode capture wrong");
    AST_SAMPLE_PINS: assert property (@(posedge SYS_CLK) disable iff (RST)
        sel_sample |-> (PIN_OUT == CORE_OUT && PIN_OE_N == CORE_OE_N))
        else $error("sample disturbed pins");
    AST_CLAMP_PINS: assert property (@(posedge SYS_CLK) disable iff (RST)
        (sel_clamp || sel_extest) |-> PIN_OUT == bsr_upd_out)
        else $error("pins not from update latch");
    AST_KEEPERS: assert property (@(posedge SYS_CLK) disable iff (RST)
        PIN_KEEPERS_ON)
        else $error("keepers turned off");
    COV_IR_LOAD: cover property (@(posedge SYS_CLK) tck_fall && state == jbt_pkg::ST_UIR);
    COV_EXTEST: cover property (@(posedge SYS_CLK) sel_extest && tck_fall && in_udr);
    COV_USER_A: cover property (@(posedge SYS_CLK) sel_user_a && sh_dr);
    COV_ID_SHIFT: cover property (@(posedge SYS_CLK) sel_idcode && sh_dr);
endmodule : jbt_tap
`default_nettype wire

// File: hw/jbt_pkg.sv
// constants of the boundary-scan test access port
package jbt_pkg;
    // ****************************************
    // instruction register
    // ****************************************
    localparam int IR_LEN = 10;
    localparam logic [9:0] IR_SAMPLE = 10'h005;
    localparam logic [9:0] IR_EXTEST = 10'h00F;
    localparam logic [9:0] IR_BYPASS = 10'h3FF;
    localparam logic [9:0] IR_USERCODE = 10'h007;
    localparam logic [9:0] IR_IDCODE = 10'h006;
    localparam logic [9:0] IR_HIGHZ = 10'h00B;
    localparam logic [9:0] IR_CLAMP = 10'h00A;
    localparam logic [9:0] IR_USER_A = 10'h00C;
    localparam logic [9:0] IR_USER_B = 10'h00E;
    // capture pattern of the instruction register, lsbs fixed 01
    localparam logic [9:0] IR_CAPTURE = 10'h001;
    // ****************************************
    // data registers
    // ****************************************
    localparam int DR_LEN = 32;
    localparam logic [31:0] USERCODE_RESET = 32'hFFFF_FFFF;
    localparam int ID_VER_POS = 28;
    localparam int ID_PART_POS = 12;
    localparam int ID_MFR_POS = 1;
    localparam int BSR_LEN_SMALL = 240;
    localparam int BSR_LEN_MID_A = 480;
    localparam int BSR_LEN_MID_B = 636;
    localparam int BSR_LEN_LARGE = 816;
    // ****************************************
    // tap controller states
    // ****************************************
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDS = 16'h0004, ST_CDR = 16'h0008,
        ST_SDR = 16'h0010, ST_E1D = 16'h0020, ST_PDR = 16'h0040, ST_E2D = 16'h0080,
        ST_UDR = 16'h0100, ST_SIS = 16'h0200, ST_CIR = 16'h0400, ST_SIR = 16'h0800,
        ST_E1I = 16'h1000, ST_PIR = 16'h2000, ST_E2I = 16'h4000, ST_UIR = 16'h8000
    } jbt_state_t;
endpackage : jbt_pkg

// File: tb/jbt_host.sv
// host model that drives the test port pins from outside
`timescale 1ns/1ps
`default_nettype none
module jbt_host (
    input wire logic SYS_CLK,
    input wire logic TDO,
    input wire logic TDO_OE_N,
    output logic TCK,
    output logic TMS,
    output logic TDI
);
    logic tx_q[$];
    logic rx_q[$];
    initial begin
        TCK = 1'b1;
        TMS = 1'b1;
        TDI = 1'b0;
    end
    // one 800 ns tck period; tdo taken just before the rising edge
    task automatic step(input logic tms, input logic tdi);
        @(posedge SYS_CLK);
        #1;
        TCK = 1'b0;
        TMS = tms;
        TDI = tdi;
        repeat (4) @(posedge SYS_CLK);
        #1;
        // released tdo reads as the host's pull-up level
        rx_q.push_back(TDO_OE_N ? 1'b1 : TDO);
        TCK = 1'b1;
        repeat (3) @(posedge SYS_CLK);
    endtask : step
    task automatic to_idle();
        repeat (5) step(1'b1, ~TDI);
        step(1'b0, ~TDI);
    endtask : to_idle
    // idle tdi toggles so a stale level is never mistaken for data
    task automatic scan(input logic is_ir);
        logic b;
        int n;
        n = tx_q.size();
        step(1'b1, ~TDI);
        if (is_ir) begin
            step(1'b1, ~TDI);
        end
        step(1'b0, ~TDI);
        step(1'b0, ~TDI);
        rx_q.delete();
        for (int i = 0; i < n; i++) begin
            b = tx_q.pop_front();
            step((i == n - 1) ? 1'b1 : 1'b0, b);
        end
        step(1'b1, ~TDI);
        step(1'b0, ~TDI);
    endtask : scan
endmodule : jbt_host
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench of the boundary-scan port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    localparam int NP = 8;
    localparam int BL = jbt_pkg::BSR_LEN_SMALL;
    logic SYS_CLK, RST, TCK, TMS, TDI, TDO, TDO_OE_N, PIN_KEEPERS_ON;
    logic [NP-1:0] PIN_IN, CORE_OUT, CORE_OE_N, PIN_OUT, PIN_OE_N, pat_d, pat_oe;
    logic USER_A_SEL, USER_B_SEL, USER_CAPTURE, USER_SHIFT, USER_UPDATE, USER_TDI;
    logic USER_A_TDO, USER_B_TDO, b;
    logic [31:0] word;
    logic exp_q[$];
    logic [9:0] codes[3] = '{jbt_pkg::IR_BYPASS, jbt_pkg::IR_HIGHZ, jbt_pkg::IR_CLAMP};
    int fails, compares, seed;
    // host step length in system clocks
    localparam int TCK_CYC = 8;
    localparam logic [31:0] ID_EXP = {4'h3, 16'h5a3c, 11'h2b1, 1'b1};
    int n_cap = 0;
    int n_shift = 0;
    int n_upd = 0;
    int c_cap, c_shift, c_upd;
    // identity fields: values arbitrary
    jbt_tap #(.BSR_LEN(BL), .N_PINS(NP), .ID_VERSION(4'h3), .ID_PART(16'h5a3c),
        .ID_MFR(11'h2b1)) i_dut (.SYS_CLK, .RST, .TCK, .TMS, .TDI, .TDO, .TDO_OE_N,
        .PIN_IN, .CORE_OUT, .CORE_OE_N, .PIN_OUT, .PIN_OE_N, .PIN_KEEPERS_ON,
        .USER_A_SEL, .USER_B_SEL, .USER_CAPTURE, .USER_SHIFT, .USER_UPDATE,
        .USER_TDI, .USER_A_TDO, .USER_B_TDO);
    jbt_host i_host (.SYS_CLK, .TDO, .TDO_OE_N, .TCK, .TMS, .TDI);
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    // user chain strobes counted in system clocks
    always @(posedge SYS_CLK) begin
        if (USER_CAPTURE === 1'b1) begin
            n_cap <= n_cap + 1;
        end
        if (USER_SHIFT === 1'b1) begin
            n_shift <= n_shift + 1;
        end
        if (USER_UPDATE === 1'b1) begin
            n_upd <= n_upd + 1;
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic get(input int n);
        word = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            word[i] = i_host.rx_q[i];
        end
    endtask : get
    task automatic load_ir(input logic [9:0] code);
        for (int i = 0; i < 10; i++) begin
            i_host.tx_q.push_back(code[i]);
        end
        i_host.scan(1'b1);
        get(10);
        `CHK(word[9:0], jbt_pkg::IR_CAPTURE)
    endtask : load_ir
    task automatic dr_zero(input int n);
        repeat (n) i_host.tx_q.push_back(1'b0);
        i_host.scan(1'b0);
        get(n);
    endtask : dr_zero
    // preload pattern goes behind the captured input cells
    task automatic bsr_scan();
        for (int i = 0; i < BL; i++) begin
            b = (i >= NP && i < 2 * NP) ? pat_d[i - NP] :
                (i >= 2 * NP && i < 3 * NP) ? pat_oe[i - 2 * NP] : 1'b0;
            i_host.tx_q.push_back(b);
        end
        i_host.scan(1'b0);
        get(3 * NP);
        `CHK(word[3*NP-1:0], {CORE_OE_N, CORE_OUT, PIN_IN})
    endtask : bsr_scan
    initial begin
        repeat (100000) @(posedge SYS_CLK);
        fails++;
        tally_and_finish();
    end
    initial begin
        seed = 18;
        RST = 1'b1;
        PIN_IN = NP'($random(seed));
        CORE_OUT = NP'($random(seed));
        CORE_OE_N = NP'($random(seed));
        pat_d = NP'($random(seed));
        pat_oe = NP'($random(seed));
        USER_A_TDO = 1'($random(seed));
        USER_B_TDO = ~USER_A_TDO;
        repeat (16) @(posedge SYS_CLK);
        #1;
        RST = 1'b0;
        repeat (4) @(posedge SYS_CLK);
        i_host.to_idle();
        dr_zero(32);
        `CHK(word, ID_EXP)
        load_ir(jbt_pkg::IR_USERCODE);
        dr_zero(32);
        `CHK(word, jbt_pkg::USERCODE_RESET)
        load_ir(jbt_pkg::IR_SAMPLE);
        #1;
        CORE_OUT = NP'($random(seed));
        CORE_OE_N = NP'($random(seed));
        @(posedge SYS_CLK);
        `CHK({PIN_OUT, PIN_OE_N}, {CORE_OUT, CORE_OE_N})
        bsr_scan();
        load_ir(jbt_pkg::IR_EXTEST);
        `CHK({PIN_OUT, PIN_OE_N}, {pat_d, pat_oe})
        `CHK(PIN_KEEPERS_ON, 1'b1)
        #1;
        PIN_IN = NP'($random(seed));
        CORE_OUT = ~CORE_OUT;
        bsr_scan();
        `CHK(PIN_OUT, pat_d)
        // bypass path modelled as a one-deep queue that captures zero
        // only supported codes are ever loaded
        foreach (codes[k]) begin
            load_ir(codes[k]);
            if (codes[k] == jbt_pkg::IR_BYPASS) begin
                `CHK({PIN_OUT, PIN_OE_N}, {CORE_OUT, CORE_OE_N})
            end
            if (codes[k] == jbt_pkg::IR_HIGHZ) begin
                `CHK(PIN_OE_N, {NP{1'b1}})
                `CHK(PIN_KEEPERS_ON, 1'b1)
            end
            if (codes[k] == jbt_pkg::IR_CLAMP) begin
                `CHK({PIN_OUT, PIN_OE_N}, {pat_d, pat_oe})
            end
            exp_q = '{1'b0};
            for (int i = 0; i < 16; i++) begin
                b = 1'($random(seed));
                i_host.tx_q.push_back(b);
                exp_q.push_back(b);
            end
            i_host.scan(1'b0);
            for (int i = 0; i < 16; i++) begin
                `CHK(i_host.rx_q[i], exp_q[i])
            end
        end
        for (int k = 0; k < 2; k++) begin
            load_ir(k == 1 ? jbt_pkg::IR_USER_B : jbt_pkg::IR_USER_A);
            `CHK({USER_A_SEL, USER_B_SEL}, (k == 1) ? 2'b01 : 2'b10)
            #1;
            USER_A_TDO = 1'($random(seed));
            USER_B_TDO = ~USER_A_TDO;
            c_cap = n_cap;
            c_shift = n_shift;
            c_upd = n_upd;
            dr_zero(4);
            #1;
            `CHK(i_host.rx_q[3], (k == 1) ? USER_B_TDO : USER_A_TDO)
            `CHK(n_cap - c_cap, TCK_CYC)
            `CHK(n_shift - c_shift, 4 * TCK_CYC)
            `CHK(n_upd - c_upd, TCK_CYC)
            `CHK(USER_TDI, TDI)
        end
        // five tms highs return to idcode
        i_host.to_idle();
        dr_zero(32);
        `CHK(word, ID_EXP)
        // reset again in mid-run, away from idcode
        load_ir(jbt_pkg::IR_BYPASS);
        #1;
        RST = 1'b1;
        repeat (2) @(posedge SYS_CLK);
        #1;
        RST = 1'b0;
        repeat (4) @(posedge SYS_CLK);
        i_host.to_idle();
        dr_zero(32);
        `CHK(word, ID_EXP)
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
